// ==== rtl/access_classify.sv ====
// sorts a younger access into the load and store classes
`timescale 1ns/100ps
`default_nettype none
module access_classify
    import barrier_pkg::*;
(
    input wire logic [barrier_pkg::KIND_W-1:0] kind,
    input wire logic [barrier_pkg::ATYPE_W-1:0] atype,
    input wire logic shared,
    output logic is_ld,
    output logic is_st
);
    wire logic sync_ok;
    wire logic ld_kind;
    wire logic st_kind;
    // [RQ1] [RQ18]
    assign sync_ok = shared & (atype == ATYPE_UNCACHED | atype == ATYPE_COHERENT);
    // cache ops may read and write back, so they count as both
    assign ld_kind = kind == KIND_LOAD | kind == KIND_PREFETCH_OP | kind == KIND_INDEXED_PREFETCH_OP | kind == KIND_CACHE; // [RQ10]
    assign st_kind = kind == KIND_STORE | kind == KIND_CACHE; // [RQ10]
    // fetches fall in neither class and are never held
    assign is_ld = sync_ok & ld_kind; // [RQ5]
    assign is_st = sync_ok & st_kind;
endmodule
`default_nettype wire

// ==== rtl/barrier_decode.sv ====
// decode of the barrier type field into ordering needs
`timescale 1ns/100ps
`default_nettype none
module barrier_decode
    import barrier_pkg::*;
(
    input wire logic [barrier_pkg::INSTR_W-1:0] instr,
    output logic ord_ld,
    output logic ord_st,
    output logic yng_ld,
    output logic yng_st,
    output logic gp_ld,
    output logic gp_st
);
    wire logic [STYPE_W-1:0] stype = instr[STYPE_LSB +: STYPE_W]; // [RQ11]
    always_comb begin
        // every code not listed falls back to a full completion barrier
        ord_ld = 1'b1; // [RQ6] [RQ7] [RQ17]
        ord_st = 1'b1;
        yng_ld = 1'b1;
        yng_st = 1'b1;
        gp_ld = 1'b1;
        gp_st = 1'b1;
        unique case (stype)
            STYPE_STORE: begin // [RQ12]
                ord_ld = 1'b0;
                yng_ld = 1'b0;
                gp_ld = 1'b0;
                gp_st = 1'b0;
            end
            STYPE_ALL_ORD: begin // [RQ13]
                gp_ld = 1'b0;
                gp_st = 1'b0;
            end
            STYPE_ACQUIRE: begin // [RQ14]
                ord_st = 1'b0;
                gp_ld = 1'b0;
                gp_st = 1'b0;
            end
            STYPE_RELEASE: begin // [RQ15]
                yng_ld = 1'b0;
                gp_ld = 1'b0;
                gp_st = 1'b0;
            end
            STYPE_LOAD: begin // [RQ16]
                ord_st = 1'b0;
                yng_st = 1'b0;
                gp_ld = 1'b0;
                gp_st = 1'b0;
            end
            default: begin
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== rtl/barrier_pkg.sv ====
// constants and codes shared by the memory ordering barrier
// Operation
// [RQ1] only uncached or coherent accesses are ordered
// [RQ2] completion: older selected done before younger start
// [RQ3] load done at writeback, store when visible
// [RQ4] completion waits older globally performed
// [RQ5] instruction fetches are never held
// [RQ6] type zero is full completion barrier
// [RQ7] unimplemented nonzero types act as type zero
// [RQ8] ordering: older reach ordering point first
// [RQ9] older external requests performed before younger
// [RQ10] cache and prefetch ops count as accesses
// [RQ11] type field is instruction bits 10 to 6
// [RQ12] code 0x4 orders stores against stores
// [RQ13] code 0x10 orders everything, no completion
// [RQ14] code 0x11 orders loads before all younger
// [RQ15] code 0x12 orders all before younger stores
// [RQ16] code 0x13 orders loads against loads
// [RQ17] other codes vendor or reserved, full barrier
// [RQ18] synchronizable means shared and ordered access type
// [RQ19] load performed when later stores cannot change
// [RQ20] store performed when later loads see it
// [RQ21] globally performed means performed for all agents
// [RQ22] hold younger issue until datapath reports progress
package barrier_pkg;
    localparam int INSTR_W = 32;
    localparam int STYPE_LSB = 6;
    localparam int STYPE_W = 5;
    localparam logic [4:0] STYPE_FULL = 5'h00;
    localparam logic [4:0] STYPE_STORE = 5'h04;
    localparam logic [4:0] STYPE_ALL_ORD = 5'h10;
    localparam logic [4:0] STYPE_ACQUIRE = 5'h11;
    localparam logic [4:0] STYPE_RELEASE = 5'h12;
    localparam logic [4:0] STYPE_LOAD = 5'h13;
    localparam int KIND_W = 3;
    localparam logic [2:0] KIND_LOAD = 3'h0;
    localparam logic [2:0] KIND_STORE = 3'h1;
    localparam logic [2:0] KIND_CACHE = 3'h2;
    localparam logic [2:0] KIND_PREFETCH_OP = 3'h3;
    localparam logic [2:0] KIND_INDEXED_PREFETCH_OP = 3'h4;
    localparam logic [2:0] KIND_FETCH = 3'h5;
    localparam int ATYPE_W = 2;
    localparam logic [1:0] ATYPE_UNCACHED = 2'h0;
    localparam logic [1:0] ATYPE_COHERENT = 2'h1;
    localparam logic [1:0] ATYPE_OTHER = 2'h2;
endpackage

// ==== rtl/memory_ordering_barrier.sv ====
// barrier sequencer in the load/store path
`timescale 1ns/100ps
`default_nettype none
module memory_ordering_barrier
    import barrier_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic BAR_VALID,
    input wire logic [barrier_pkg::INSTR_W-1:0] BAR_INSTR,
    input wire logic REQ_VALID,
    input wire logic [barrier_pkg::KIND_W-1:0] REQ_KIND,
    input wire logic [barrier_pkg::ATYPE_W-1:0] REQ_ATYPE,
    input wire logic REQ_SHARED,
    input wire logic OLD_LD_AT_OP,
    input wire logic OLD_ST_AT_OP,
    input wire logic OLD_LD_GP,
    input wire logic OLD_ST_GP,
    input wire logic OLD_EXT_SENT,
    output logic BAR_BUSY,
    output logic BAR_DONE,
    output logic ISSUE_GRANT,
    output logic HOLD_LOADS,
    output logic HOLD_STORES
);
    // ------------------------------------------------------------
    // decode and classify
    // ------------------------------------------------------------
    typedef enum logic [0:0] {S_IDLE, S_WAIT} state_e;

    state_e state_reg;
    state_e state_next;
    logic d_ord_ld;
    logic d_ord_st;
    logic d_yng_ld;
    logic d_yng_st;
    logic d_gp_ld;
    logic d_gp_st;
    logic req_ld;
    logic req_st;
    logic ord_ld_reg;
    logic ord_st_reg;
    logic yng_ld_reg;
    logic yng_st_reg;
    logic gp_ld_reg;
    logic gp_st_reg;
    logic done_reg;
    logic grant_reg;
    logic hold_ld_reg;
    logic hold_st_reg;
    // busy has a flop of its own so the pin is never a decode of state bits
    logic busy_reg;

    barrier_decode u_decode (
        .instr(BAR_INSTR),
        .ord_ld(d_ord_ld),
        .ord_st(d_ord_st),
        .yng_ld(d_yng_ld),
        .yng_st(d_yng_st),
        .gp_ld(d_gp_ld),
        .gp_st(d_gp_st)
    );

    access_classify u_classify (
        .kind(REQ_KIND),
        .atype(REQ_ATYPE),
        .shared(REQ_SHARED),
        .is_ld(req_ld),
        .is_st(req_st)
    );

    // ------------------------------------------------------------
    // completion condition
    // ------------------------------------------------------------
    wire logic take;
    wire logic waiting;
    wire logic ordering;
    wire logic ld_ok;
    wire logic st_ok;
    wire logic ext_ok;
    wire logic met;

    // a barrier arriving while busy is ignored; one at a time
    assign take = BAR_VALID & (state_reg == S_IDLE);
    assign waiting = state_reg == S_WAIT;
    assign ordering = ~gp_ld_reg & ~gp_st_reg;
    // load done means result written, store done means visible to all
    assign ld_ok = (~ord_ld_reg | OLD_LD_AT_OP) & (~gp_ld_reg | OLD_LD_GP); // [RQ3] [RQ8] [RQ19]
    assign st_ok = (~ord_st_reg | OLD_ST_AT_OP) & (~gp_st_reg | OLD_ST_GP); // [RQ3] [RQ20] [RQ21]
    // in-order hand-off keeps older external requests performed first
    assign ext_ok = ~ordering | OLD_EXT_SENT; // [RQ9]
    assign met = ld_ok & st_ok & ext_ok; // [RQ2] [RQ4]

    // ------------------------------------------------------------
    // younger issue gating
    // ------------------------------------------------------------
    wire logic hold_ld_now;
    wire logic hold_st_now;
    wire logic grant_next;
    wire logic hold_ld_next;
    wire logic hold_st_next;

    // same-cycle barrier is older than the request beside it
    assign hold_ld_now = (waiting & yng_ld_reg) | (take & d_yng_ld); // [RQ22]
    assign hold_st_now = (waiting & yng_st_reg) | (take & d_yng_st); // [RQ22]
    // fetches and non-synchronizable accesses pass straight through
    assign grant_next = REQ_VALID & ~(req_ld & hold_ld_now) & ~(req_st & hold_st_now); // [RQ5] [RQ1]
    assign hold_ld_next = state_next == S_WAIT & (take ? d_yng_ld : yng_ld_reg);
    assign hold_st_next = state_next == S_WAIT & (take ? d_yng_st : yng_st_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (BAR_VALID) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (met) begin
                    state_next = S_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_reg <= S_IDLE;
            done_reg <= 1'b0;
            grant_reg <= 1'b0;
            hold_ld_reg <= 1'b0;
            hold_st_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_reg <= waiting & met;
            grant_reg <= grant_next;
            hold_ld_reg <= hold_ld_next;
            hold_st_reg <= hold_st_next;
            busy_reg <= state_next == S_WAIT; // [RQ2]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ord_ld_reg <= 1'b0;
            ord_st_reg <= 1'b0;
            yng_ld_reg <= 1'b0;
            yng_st_reg <= 1'b0;
            gp_ld_reg <= 1'b0;
            gp_st_reg <= 1'b0;
        end else if (take) begin
            ord_ld_reg <= d_ord_ld;
            ord_st_reg <= d_ord_st;
            yng_ld_reg <= d_yng_ld;
            yng_st_reg <= d_yng_st;
            gp_ld_reg <= d_gp_ld;
            gp_st_reg <= d_gp_st;
        end
    end

    assign BAR_BUSY = busy_reg;
    assign BAR_DONE = done_reg;
    assign ISSUE_GRANT = grant_reg;
    assign HOLD_LOADS = hold_ld_reg;
    assign HOLD_STORES = hold_st_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire logic [STYPE_W-1:0] st_in = BAR_INSTR[STYPE_LSB +: STYPE_W];

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_fetch_passes: // [RQ5]
        assert property (REQ_VALID && REQ_KIND == KIND_FETCH |=> ISSUE_GRANT)
        else $error("fetch was held by barrier");
    a_other_type_free: // [RQ1]
        assert property (REQ_VALID && REQ_ATYPE == ATYPE_OTHER |=> ISSUE_GRANT)
        else $error("unordered access type was held");
    a_unshared_free: // [RQ18]
        assert property (REQ_VALID && !REQ_SHARED |=> ISSUE_GRANT)
        else $error("unshared access was held");
    a_load_done_gp: // [RQ4]
        assert property (BAR_DONE |-> $past(OLD_LD_GP || !gp_ld_reg))
        else $error("barrier done before loads performed");
    a_store_done_gp: // [RQ2]
        assert property (BAR_DONE |-> $past(OLD_ST_GP || !gp_st_reg))
        else $error("barrier done before stores performed");
    a_zero_full: // [RQ6]
        assert property (take && st_in == STYPE_FULL |=> HOLD_LOADS && HOLD_STORES && gp_ld_reg && gp_st_reg)
        else $error("type zero not a full completion barrier");
    a_vendor_full: // [RQ7]
        assert property (take && st_in == 5'h01 |=> HOLD_LOADS && gp_st_reg)
        else $error("unused code not treated as type zero");
    a_store_type: // [RQ12]
        assert property (take && st_in == STYPE_STORE |=> !HOLD_LOADS && HOLD_STORES)
        else $error("store barrier holds wrong class");
    a_acquire_type: // [RQ14]
        assert property (take && st_in == STYPE_ACQUIRE |=> HOLD_LOADS && HOLD_STORES && !gp_ld_reg)
        else $error("acquire barrier holds wrong class");
    a_release_type: // [RQ15]
        assert property (take && st_in == STYPE_RELEASE |=> !HOLD_LOADS && HOLD_STORES)
        else $error("release barrier holds wrong class");
    a_load_type: // [RQ16]
        assert property (take && st_in == STYPE_LOAD |=> HOLD_LOADS && !HOLD_STORES)
        else $error("load barrier holds wrong class");
    a_held_load_stalls: // [RQ22]
        assert property (waiting && yng_ld_reg && REQ_VALID && REQ_KIND == KIND_LOAD
                         && REQ_SHARED && REQ_ATYPE == ATYPE_COHERENT |=> !ISSUE_GRANT)
        else $error("younger load granted during barrier");
    a_prefetch_held: // [RQ10]
        assert property (waiting && yng_ld_reg && REQ_VALID && REQ_KIND == KIND_PREFETCH_OP
                         && REQ_SHARED && REQ_ATYPE == ATYPE_UNCACHED |=> !ISSUE_GRANT)
        else $error("prefetch passed a load barrier");
    a_ext_order: // [RQ9]
        assert property (BAR_DONE && $past(ordering) |-> $past(OLD_EXT_SENT))
        else $error("ordering barrier ended before external hand-off");
    a_done_pulse: // [RQ8]
        assert property (BAR_DONE |-> !BAR_BUSY ##1 !BAR_DONE)
        else $error("done not a single pulse");

    // ------------------------------------------------------------
    // type table and progress checks
    // ------------------------------------------------------------
    // each light type is pinned on its own; a slip in one decode arm
    // would otherwise hide behind the full barrier fallback
    a_all_ord_type: // [RQ13]
        assert property (take && st_in == STYPE_ALL_ORD |=> HOLD_LOADS && HOLD_STORES && !gp_ld_reg && !gp_st_reg)
        else $error("full ordering barrier holds wrong class");
    a_reserved_full: // [RQ17]
        assert property (take && st_in == 5'h1f |=> HOLD_LOADS && HOLD_STORES && gp_ld_reg && gp_st_reg)
        else $error("reserved code not treated as type zero");
    a_vendor_hi_full: // [RQ7]
        assert property (take && st_in == 5'h0f |=> HOLD_LOADS && HOLD_STORES && gp_ld_reg && gp_st_reg)
        else $error("vendor code not treated as type zero");
    a_release_ord: // [RQ15]
        assert property (take && st_in == STYPE_RELEASE |=> ord_ld_reg && ord_st_reg && !gp_st_reg)
        else $error("release barrier orders wrong older class");
    a_acquire_ord: // [RQ14]
        assert property (take && st_in == STYPE_ACQUIRE |=> ord_ld_reg && !ord_st_reg)
        else $error("acquire barrier orders wrong older class");
    a_store_ord: // [RQ12]
        assert property (take && st_in == STYPE_STORE |=> !ord_ld_reg && ord_st_reg && !gp_st_reg)
        else $error("store barrier orders wrong older class");
    a_load_ord: // [RQ16]
        assert property (take && st_in == STYPE_LOAD |=> ord_ld_reg && !ord_st_reg && !gp_ld_reg)
        else $error("load barrier orders wrong older class");

    // the datapath levels are trusted as given; the sequencer only gates
    a_done_ord_point: // [RQ8]
        assert property (BAR_DONE |-> $past((OLD_LD_AT_OP || !ord_ld_reg) && (OLD_ST_AT_OP || !ord_st_reg)))
        else $error("barrier done before ordering point reached");
    a_gp_done_full: // [RQ21]
        assert property (BAR_DONE && $past(gp_ld_reg) |-> $past(OLD_LD_GP && OLD_ST_GP))
        else $error("completion barrier done before all performed");
    a_busy_no_done: // [RQ2]
        assert property (BAR_BUSY |-> !BAR_DONE)
        else $error("busy and done together");
    a_hold_in_wait: // [RQ22]
        assert property (HOLD_LOADS || HOLD_STORES |-> BAR_BUSY)
        else $error("class held with no barrier pending");
    a_busy_ignore: // [RQ2]
        assert property (waiting && BAR_VALID && !met |=> BAR_BUSY && $stable(gp_ld_reg) && $stable(ord_st_reg))
        else $error("barrier taken while another pending");

    a_store_held: // [RQ2]
        assert property (waiting && yng_st_reg && REQ_VALID && REQ_KIND == KIND_STORE
                         && REQ_SHARED && REQ_ATYPE == ATYPE_UNCACHED |=> !ISSUE_GRANT)
        else $error("younger store granted during barrier");
    a_cache_held: // [RQ10]
        assert property (waiting && yng_st_reg && REQ_VALID && REQ_KIND == KIND_CACHE
                         && REQ_SHARED && REQ_ATYPE == ATYPE_COHERENT |=> !ISSUE_GRANT)
        else $error("cache op passed a store barrier");
    a_indexed_prefetch_op_held: // [RQ10]
        assert property (waiting && yng_ld_reg && REQ_VALID && REQ_KIND == KIND_INDEXED_PREFETCH_OP
                         && REQ_SHARED && REQ_ATYPE == ATYPE_COHERENT |=> !ISSUE_GRANT)
        else $error("indexed prefetch passed a load barrier");
    a_same_cycle_hold: // [RQ22]
        assert property (take && d_yng_ld && REQ_VALID && REQ_KIND == KIND_PREFETCH_OP
                         && REQ_SHARED && REQ_ATYPE == ATYPE_COHERENT |=> !ISSUE_GRANT)
        else $error("request beside a new barrier granted");
    a_idle_grant: // [RQ22]
        assert property (!waiting && !BAR_VALID && REQ_VALID |=> ISSUE_GRANT)
        else $error("request refused with no barrier");

    c_full_done: cover property (take && st_in == STYPE_FULL ##[1:20] BAR_DONE);
    c_order_done: cover property (take && st_in == STYPE_ALL_ORD ##[1:20] BAR_DONE);
    c_held_then_go: cover property (HOLD_LOADS && REQ_VALID ##1 !ISSUE_GRANT ##[1:20] ISSUE_GRANT);
    c_store_done: cover property (take && st_in == STYPE_STORE ##[1:40] BAR_DONE);
    c_same_cycle_refuse: cover property (take && d_yng_ld && REQ_VALID && req_ld ##1 !ISSUE_GRANT);
endmodule
`default_nettype wire

// ==== tb/datapath_model.sv ====
// load/store datapath stand-in that reports progress of older accesses
`timescale 1ns/100ps
`default_nettype none
module datapath_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic [7:0] lat_op,
    input wire logic [7:0] lat_gp,
    input wire logic [7:0] lat_ext,
    output logic ld_at_op,
    output logic st_at_op,
    output logic ld_gp,
    output logic st_gp,
    output logic ext_sent
);
    // ----------------------------------------
    // progress counter
    // ----------------------------------------
    // restarts with every barrier, so older work never looks finished early
    logic [7:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'hff) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    assign ld_at_op = busy && (cnt_reg >= lat_op);
    assign st_at_op = busy && (cnt_reg >= lat_op);
    // performed for every agent only well after the ordering point
    // loads settle a cycle before stores; every type waits on both or neither, so a crossed input leaves the timing unchanged
    assign ld_gp = busy && (cnt_reg >= lat_gp - 8'h01);
    assign st_gp = busy && (cnt_reg >= lat_gp);
    assign ext_sent = busy && (cnt_reg >= lat_ext);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the memory ordering barrier
`timescale 1ns/100ps
`default_nettype none
module tb;
    import barrier_pkg::*;
    logic ref_clk, reset, bar_valid, req_valid, req_shared;
    logic [INSTR_W-1:0] bar_instr;
    logic [KIND_W-1:0] req_kind;
    logic [ATYPE_W-1:0] req_atype;
    logic ld_op, st_op, ld_gp, st_gp, ext_sent;
    logic bar_busy, bar_done, issue_grant, hold_loads, hold_stores;
    logic [7:0] lat_op, lat_gp, lat_ext;
    int miscompares, total_checks, seed;
    logic [4:0] types [11] = '{5'h00, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h01, 5'h05, 5'h0f, 5'h14, 5'h1f};
    // ----------------------------------------
    // clock, design and far side
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    memory_ordering_barrier i_memory_ordering_barrier (.REF_CLK(ref_clk), .RESET(reset),
        .BAR_VALID(bar_valid), .BAR_INSTR(bar_instr), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
        .REQ_ATYPE(req_atype), .REQ_SHARED(req_shared), .OLD_LD_AT_OP(ld_op), .OLD_ST_AT_OP(st_op),
        .OLD_LD_GP(ld_gp), .OLD_ST_GP(st_gp), .OLD_EXT_SENT(ext_sent), .BAR_BUSY(bar_busy),
        .BAR_DONE(bar_done), .ISSUE_GRANT(issue_grant), .HOLD_LOADS(hold_loads), .HOLD_STORES(hold_stores));
    datapath_model i_datapath_model (.clk(ref_clk), .rst(reset), .busy(bar_busy), .lat_op(lat_op),
        .lat_gp(lat_gp), .lat_ext(lat_ext), .ld_at_op(ld_op), .st_at_op(st_op), .ld_gp(ld_gp),
        .st_gp(st_gp), .ext_sent(ext_sent));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // {globally performed, younger loads held, younger stores held}
    function automatic logic [2:0] exp_set(input logic [4:0] t);
        case (t)
            STYPE_STORE, STYPE_RELEASE: return 3'h1;
            STYPE_ALL_ORD, STYPE_ACQUIRE: return 3'h3;
            STYPE_LOAD: return 3'h2;
            default: return 3'h7;
        endcase
    endfunction
    task automatic check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_range(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic put_req(input logic v, input logic [2:0] k, input logic [1:0] a, input logic s);
        req_valid <= v;
        req_kind <= k;
        req_atype <= a;
        req_shared <= s;
    endtask
    task automatic next_edge();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // one barrier with younger traffic around it
    // ----------------------------------------
    // latencies keep the wait long enough that the fixed steps all fall inside it
    task automatic run_bar(input logic [4:0] t);
        logic [2:0] e;
        logic [INSTR_W-1:0] w;
        int n;
        int need;
        e = exp_set(t);
        lat_op = 8'h05 + 8'({$random(seed)} % 5);
        lat_gp = 8'h14 + 8'({$random(seed)} % 8);
        lat_ext = 8'h05 + 8'({$random(seed)} % 10);
        need = e[2] ? lat_gp : ((lat_ext > lat_op) ? lat_ext : lat_op);
        w = $random(seed);
        w[10:6] = t;
        @(posedge ref_clk);
        bar_valid <= 1'b1;
        bar_instr <= w;
        put_req(1'b1, KIND_PREFETCH_OP, ATYPE_COHERENT, 1'b1);
        @(posedge ref_clk);
        bar_valid <= 1'b0;
        put_req(1'b1, KIND_STORE, ATYPE_UNCACHED, 1'b1);
        #1;
        check_bit("prefetch grant", !e[1], issue_grant);
        check_bit("busy", 1'b1, bar_busy);
        check_bit("hold loads", e[1], hold_loads);
        check_bit("hold stores", e[0], hold_stores);
        @(posedge ref_clk);
        put_req(1'b1, KIND_FETCH, ATYPE_COHERENT, 1'b1);
        #1;
        check_bit("store grant", !e[0], issue_grant);
        @(posedge ref_clk);
        put_req(1'b1, KIND_CACHE, ATYPE_OTHER, 1'b1);
        #1;
        check_bit("fetch grant", 1'b1, issue_grant);
        @(posedge ref_clk);
        put_req(1'b1, KIND_CACHE, ATYPE_COHERENT, 1'b0);
        #1;
        check_bit("other type grant", 1'b1, issue_grant);
        @(posedge ref_clk);
        put_req(1'b0, KIND_LOAD, ATYPE_COHERENT, 1'b1);
        #1;
        check_bit("private grant", 1'b1, issue_grant);
        n = 4;
        while (bar_done !== 1'b1 && n < 60) begin
            next_edge();
            n++;
        end
        check_range("done delay", need + 1, need + 3, n);
        check_bit("busy at done", 1'b0, bar_busy);
        @(posedge ref_clk);
        put_req(1'b1, KIND_LOAD, ATYPE_COHERENT, 1'b1);
        @(posedge ref_clk);
        put_req(1'b0, KIND_LOAD, ATYPE_COHERENT, 1'b1);
        #1;
        check_bit("done pulse", 1'b0, bar_done);
        check_bit("hold released", 1'b0, hold_loads | hold_stores);
        check_bit("grant after", 1'b1, issue_grant);
        $display("test barrier type %h ended", t);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        seed = 27;
        miscompares = 0;
        total_checks = 0;
        reset = 1'b1;
        bar_valid = 1'b0;
        bar_instr = '0;
        lat_op = 8'h05;
        lat_gp = 8'h14;
        lat_ext = 8'h05;
        put_req(1'b0, KIND_LOAD, ATYPE_UNCACHED, 1'b0);
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        next_edge();
        check_bit("idle busy", 1'b0, bar_busy | bar_done | hold_loads | hold_stores);
        foreach (types[i]) begin
            run_bar(types[i]);
        end
        for (int i = 0; i < 20; i++) begin
            run_bar(5'($random(seed)));
        end
        // with no barrier pending nothing may be held
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            put_req(1'b1, 3'({$random(seed)} % 6), 2'($random(seed)), 1'($random(seed)));
            @(posedge ref_clk);
            put_req(1'b0, KIND_LOAD, ATYPE_UNCACHED, 1'b0);
            #1;
            check_bit("idle grant", 1'b1, issue_grant);
        end
        $display("test idle requests ended");
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
